// file: include/gsm_map.svh
`ifndef GSM_MAP_SVH
`define GSM_MAP_SVH
// register byte offsets
`define GSM_CTRL_OFS    8'h00
`define GSM_CLKDIV_OFS  8'h04
`define GSM_STATUS_OFS  8'h08
`define GSM_TXDATA_OFS  8'h0C
`define GSM_RXDATA_OFS  8'h10
`define GSM_IRQST_OFS   8'h14
`define GSM_IRQMSK_OFS  8'h18
// control fields
`define GSM_CTRL_CPOL   0
`define GSM_CTRL_CPHA   1
`define GSM_CTRL_LSBF   2
`define GSM_CTRL_MODE0  3
`define GSM_CTRL_MODE1  4
`define GSM_CTRL_DIROUT 5
`define GSM_CTRL_CSEN   6
`define GSM_CTRL_ARD    7
// status / irq fields
`define GSM_ST_TXE      0
`define GSM_ST_RXF      1
`define GSM_ST_BUSY     2
// reset values
`define GSM_CTRL_RST    8'h00
`define GSM_CLKDIV_RST  8'h01
`define GSM_IRQMSK_RST  8'h00
`define GSM_DEF_DIV     8'h01
// source clock of the serial clock generator
`define GSM_SRC_MHZ     48
`define GSM_BYTE_BITS   8
`endif

// file: include/gsm_pkg.sv
package gsm_pkg;
  typedef enum logic [1:0] {
    GSM_FULL,
    GSM_HALF,
    GSM_DUAL
  } gsm_mode_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } gsm_bus_t;
  typedef struct packed {
    logic sck;
    logic csN;
    logic dout;
    logic doutEn;
  } gsm_pins_t;
endpackage

// file: logic/gsm_clk_gen.sv
`timescale 1ns/1ps
// half-period tick generator for the serial clock
module gsm_clk_gen #(
  parameter int DW = 8
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic run,
  input wire logic [DW-1:0] div,
  output logic tick
);
  logic [DW-1:0] cnt_reg;
  always_ff @(posedge ref_clk) begin
    if (rst || !run) begin
      cnt_reg <= '0;
    end else if (cnt_reg >= div) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end
  // zero divider still ticks every cycle
  assign tick = run && (cnt_reg >= div);
endmodule

// file: logic/general_spi_master.sv
// The implementer's own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`include "gsm_map.svh"
module general_spi_master
  import gsm_pkg::*;
#(
  parameter int DIV_W = 8
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  input wire logic serial_in_pin,
  input wire logic serial_out_pin_in,
  output logic serial_out_pin,
  output logic bidir_output_enable,
  output logic serial_clock_out,
  output logic chip_select_out_n,
  output logic tx_dma_request,
  output logic rx_dma_request,
  output logic tx_irq,
  output logic rx_irq,
  output logic irq
);
  logic [7:0] ctrl_reg;
  logic [DIV_W-1:0] div_reg;
  logic [7:0] txData_reg;
  logic txFull_reg;
  logic [7:0] rxData_reg;
  logic rxFull_reg;
  logic [7:0] shOut_reg;
  logic [7:0] shIn_reg;
  logic [3:0] bitCnt_reg;
  logic busy_reg;
  logic phase_reg;
  logic sck_reg;
  logic dout_reg;
  logic [1:0] irqSt_reg;
  logic [1:0] irqMsk_reg;
  logic [7:0] regRdata_reg;
  logic [1:0] inSync0_reg;
  logic [1:0] inSync1_reg;
  logic tick;
  logic byteDone;
  logic loadNow;
  logic txEmpty;
  logic cpol;
  logic cpha;
  logic lsbf;
  gsm_mode_t mode;
  logic [3:0] bitsPerByte;
  logic wrTx;
  logic rdRx;
  logic sampleEdge;
  logic shiftEdge;
  logic inBit0;
  logic inBit1;
  logic [7:0] shInNext;

  assign cpol = ctrl_reg[`GSM_CTRL_CPOL];
  assign cpha = ctrl_reg[`GSM_CTRL_CPHA];
  assign lsbf = ctrl_reg[`GSM_CTRL_LSBF];
  always_comb begin
    case ({ctrl_reg[`GSM_CTRL_MODE1], ctrl_reg[`GSM_CTRL_MODE0]})
      2'b01: mode = GSM_HALF;
      2'b10: mode = GSM_DUAL;
      default: mode = GSM_FULL;
    endcase
  end
  assign wrTx = regWr && (regAddr == `GSM_TXDATA_OFS);
  assign rdRx = regRd && (regAddr == `GSM_RXDATA_OFS);
  assign txEmpty = !txFull_reg;
  // dual mode takes two bits per clock, so four clocks per byte
  assign bitsPerByte = (mode == GSM_DUAL) ? 4'h4 : 4'h8;

  // divider source is ref_clk standing in for the 48MHz domain
  gsm_clk_gen #(
    .DW(DIV_W)
  ) u_clk (
    .ref_clk(ref_clk),
    .rst(rst),
    .run(busy_reg),
    .div(div_reg),
    .tick(tick)
  );

  // pin inputs pass two flops before use
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      inSync0_reg <= 2'b00;
      inSync1_reg <= 2'b00;
    end else begin
      inSync0_reg <= {serial_out_pin_in, serial_in_pin};
      inSync1_reg <= inSync0_reg;
    end
  end
  assign inBit0 = inSync1_reg[0];
  assign inBit1 = inSync1_reg[1];

  // phase 0 = leading edge, phase 1 = trailing edge of each bit
  assign sampleEdge = tick && (phase_reg == cpha);
  assign shiftEdge = tick && (phase_reg != cpha);
  assign byteDone = tick && phase_reg && (bitCnt_reg == bitsPerByte - 4'h1);
  assign loadNow = txFull_reg && (!busy_reg || byteDone);

  // next receive shift value, also used when the last sample meets byteDone
  always_comb begin
    if (mode == GSM_DUAL) begin
      shInNext = {shIn_reg[5:0], inBit1, inBit0};
    end else if (mode == GSM_HALF) begin
      shInNext = lsbf ? {inBit1, shIn_reg[7:1]} : {shIn_reg[6:0], inBit1};
    end else begin
      shInNext = lsbf ? {inBit0, shIn_reg[7:1]} : {shIn_reg[6:0], inBit0};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      busy_reg <= 1'b0;
      phase_reg <= 1'b0;
      bitCnt_reg <= 4'h0;
      sck_reg <= 1'b0;
      shOut_reg <= 8'h00;
      shIn_reg <= 8'h00;
      dout_reg <= 1'b0;
    end else if (loadNow) begin
      // next byte follows with no idle clock when already waiting
      busy_reg <= 1'b1;
      phase_reg <= 1'b0;
      bitCnt_reg <= 4'h0;
      sck_reg <= 1'b0;
      shOut_reg <= txData_reg;
      dout_reg <= cpha ? dout_reg : (lsbf ? txData_reg[0] : txData_reg[7]);
    end else if (byteDone) begin
      busy_reg <= 1'b0;
      phase_reg <= 1'b0;
      sck_reg <= 1'b0;
    end else if (tick) begin
      phase_reg <= !phase_reg;
      sck_reg <= !sck_reg;
      if (phase_reg) begin
        bitCnt_reg <= bitCnt_reg + 4'h1;
      end
      if (sampleEdge) begin
        shIn_reg <= shInNext;
      end
      if (shiftEdge) begin
        // first bit of a trailing-phase byte is presented, not shifted
        if (cpha && bitCnt_reg == 4'h0) begin
          dout_reg <= lsbf ? shOut_reg[0] : shOut_reg[7];
        end else begin
          shOut_reg <= lsbf ? {1'b0, shOut_reg[7:1]} : {shOut_reg[6:0], 1'b0};
          dout_reg <= lsbf ? shOut_reg[1] : shOut_reg[6];
        end
      end
    end
  end

  // transmit holding register and empty flag
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      txData_reg <= 8'h00;
      txFull_reg <= 1'b0;
    end else begin
      if (wrTx) begin
        txData_reg <= regWdata;
      end
      if (wrTx) begin
        txFull_reg <= 1'b1;
      end else if (loadNow) begin
        txFull_reg <= 1'b0;
      end else if (rdRx && ctrl_reg[`GSM_CTRL_ARD]) begin
        // auto read re-sends the held dummy byte
        txFull_reg <= 1'b1;
      end
    end
  end

  // receive register; completion wins over a same-cycle read
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rxData_reg <= 8'h00;
      rxFull_reg <= 1'b0;
    end else if (byteDone) begin
      // with trailing-edge sampling the last bit arrives on the done tick
      rxData_reg <= sampleEdge ? shInNext : shIn_reg;
      rxFull_reg <= 1'b1;
    end else if (rdRx) begin
      rxFull_reg <= 1'b0;
    end
  end

  // control and divider registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_reg <= `GSM_CTRL_RST;
      div_reg <= DIV_W'(`GSM_CLKDIV_RST);
    end else if (regWr && regAddr == `GSM_CTRL_OFS) begin
      ctrl_reg <= regWdata;
    end else if (regWr && regAddr == `GSM_CLKDIV_OFS) begin
      div_reg <= DIV_W'(regWdata);
    end
  end

  // sticky event bits: set beats write-one clear
  logic [1:0] irqSet;
  logic [1:0] irqClr;
  assign irqSet = {byteDone, loadNow};
  assign irqClr = (regWr && regAddr == `GSM_IRQST_OFS) ? regWdata[1:0] : 2'b00;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irqSt_reg <= 2'b00;
      irqMsk_reg <= 2'b00;
    end else begin
      irqSt_reg <= (irqSt_reg & ~irqClr) | irqSet;
      if (regWr && regAddr == `GSM_IRQMSK_OFS) begin
        irqMsk_reg <= regWdata[1:0];
      end
    end
  end
  assign irq = |(irqSt_reg & irqMsk_reg);

  // read data one cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      regRdata_reg <= 8'h00;
    end else if (regRd) begin
      case (regAddr)
        `GSM_CTRL_OFS: regRdata_reg <= ctrl_reg;
        `GSM_CLKDIV_OFS: regRdata_reg <= 8'(div_reg);
        `GSM_STATUS_OFS: regRdata_reg <= {5'h00, busy_reg, rxFull_reg, txEmpty};
        `GSM_TXDATA_OFS: regRdata_reg <= txData_reg;
        `GSM_RXDATA_OFS: regRdata_reg <= rxData_reg;
        `GSM_IRQST_OFS: regRdata_reg <= {6'h00, irqSt_reg};
        `GSM_IRQMSK_OFS: regRdata_reg <= {6'h00, irqMsk_reg};
        default: regRdata_reg <= 8'h00;
      endcase
    end else begin
      regRdata_reg <= 8'h00;
    end
  end
  assign regRdata = regRdata_reg;

  assign serial_clock_out = sck_reg ^ cpol;
  // chip select follows the software enable bit across bytes
  assign chip_select_out_n = !ctrl_reg[`GSM_CTRL_CSEN];
  assign serial_out_pin = dout_reg;
  // dual reads and half-duplex receive release the pin
  assign bidir_output_enable = (mode == GSM_FULL) ||
    (mode == GSM_HALF && ctrl_reg[`GSM_CTRL_DIROUT]);
  assign tx_irq = txEmpty;
  assign rx_irq = rxFull_reg;
  assign tx_dma_request = txEmpty;
  assign rx_dma_request = rxFull_reg;
endmodule

// file: tb/gsm_sva.sv
`timescale 1ns/1ps
module gsm_sva_chk (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regRdata,
  input wire logic bidir_output_enable,
  input wire logic chip_select_out_n,
  input wire logic tx_dma_request,
  input wire logic rx_dma_request,
  input wire logic tx_irq,
  input wire logic rx_irq,
  input wire logic irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic mskSeen;
  // irq may only rise once software has opened the mask
  always_ff @(posedge ref_clk) begin
    if (rst)
      mskSeen <= 1'b0;
    else if (regWr && regAddr == 8'h18 && regWdata != 8'h00)
      mskSeen <= 1'b1;
  end
  tx_dma_a: assert property (tx_dma_request == tx_irq) else $error("tx dma differs");
  rx_dma_a: assert property (rx_dma_request == rx_irq) else $error("rx dma differs");
  rst_state_a: assert property (disable iff (1'b0) rst |=> tx_irq && !rx_irq
    && chip_select_out_n && !irq) else $error("bad reset state");
  rdata_idle_a: assert property (!$past(regRd) |-> regRdata == 8'h00)
    else $error("read data outside slot");
  tx_take_a: assert property (regWr && regAddr == 8'h0C |=> !tx_irq)
    else $error("tx empty kept after write");
  cs_hold_a: assert property ($changed(chip_select_out_n) |->
    $past(regWr) && $past(regAddr) == 8'h00) else $error("cs moved alone");
  oe_ctrl_a: assert property ($changed(bidir_output_enable) |->
    $past(regWr) && $past(regAddr) == 8'h00) else $error("oe moved alone");
  irq_mask_a: assert property (!mskSeen |-> !irq) else $error("irq while masked");
  status_view_a: assert property (regRd && regAddr == 8'h08 |=>
    regRdata[1:0] == {$past(rx_irq), $past(tx_irq)}) else $error("status mismatch");
endmodule
bind general_spi_master gsm_sva_chk u_chk (.ref_clk(ref_clk), .rst(rst),
  .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
  .regRdata(regRdata), .bidir_output_enable(bidir_output_enable),
  .chip_select_out_n(chip_select_out_n), .tx_dma_request(tx_dma_request),
  .rx_dma_request(rx_dma_request), .tx_irq(tx_irq), .rx_irq(rx_irq), .irq(irq));

// file: tb/gsm_peer.sv
`timescale 1ns/1ps
module gsm_peer (
  input wire logic sck,
  input wire logic csN,
  input wire logic mosi,
  input wire logic [7:0] reply,
  output logic sdo,
  output logic [7:0] got
);
  logic [7:0] sh;
  logic lastBit;
  int cnt;
  initial begin
    sh = 8'h00;
    got = 8'h00;
    lastBit = 1'b0;
    cnt = 0;
  end
  always @(negedge csN) begin
    sh = reply;
    cnt = 0;
  end
  // released line shows the inverse of its last bit
  always @(posedge csN) lastBit = sh[7];
  always @(posedge sck) if (!csN) got = {got[6:0], mosi};
  always @(negedge sck) begin
    if (!csN) begin
      cnt = cnt + 1;
      sh = (cnt == 8) ? reply : {sh[6:0], 1'b0};
      if (cnt == 8)
        cnt = 0;
    end
  end
  assign sdo = csN ? ~lastBit : sh[7];
endmodule

// file: tb/test_general_spi_master.sv
`timescale 1ns/1ps
module test_general_spi_master;
  import gsm_pkg::*;
  logic ref_clk = 1'b0, rst = 1'b1, regWr = 1'b0, regRd = 1'b0, halfSel = 1'b0;
  logic [7:0] regAddr = 8'h00, regWdata = 8'h00, regRdata, reply = 8'h00, got, rv;
  logic sdo, sOut, oe, sck, csN, txDma, rxDma, txIrq, rxIrq, irq;
  int num_errors = 0, checks = 0, cyc = 0;
  general_spi_master DUT (.ref_clk(ref_clk), .rst(rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .serial_in_pin(halfSel ? ~sdo : sdo), .serial_out_pin_in(oe ? sOut : sdo),
    .serial_out_pin(sOut), .bidir_output_enable(oe), .serial_clock_out(sck),
    .chip_select_out_n(csN), .tx_dma_request(txDma), .rx_dma_request(rxDma),
    .tx_irq(txIrq), .rx_irq(rxIrq), .irq(irq));
  gsm_peer u_peer (.sck(sck), .csN(csN), .mosi(sOut), .reply(reply), .sdo(sdo), .got(got));
  always #10 ref_clk = ~ref_clk;
  task automatic give_verdict();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      give_verdict();
    end
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    checks++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1 rv = regRdata;
  endtask
  task automatic waitRx();
    for (int i = 0; i < 400 && rxIrq !== 1'b1; i++)
      @(posedge ref_clk);
    #1;
    chk("rx_irq", 8'h01, {7'h00, rxIrq});
  endtask
  task automatic t_reset();
    chk("pins", 8'h03, {6'h00, csN, txDma});
    rd(8'h08);
    chk("status", 8'h01, rv);
    rd(8'h04);
    chk("clkdiv", 8'h01, rv);
    rd(8'hFC);
    chk("unmapped", 8'h00, rv);
    $display("reset test done");
  endtask
  task automatic t_full();
    wr(8'h04, 8'h03);
    wr(8'h40 >> 6, 8'h00);
    reply = 8'h3C;
    wr(8'h00, 8'h40);
    wr(8'h0C, 8'hA5);
    waitRx();
    rd(8'h10);
    chk("rxdata", 8'h3C, rv);
    chk("peer got", 8'hA5, got);
    rd(8'h08);
    chk("status", 8'h01, rv);
    $display("full duplex test done");
  endtask
  task automatic t_b2b();
    wr(8'h00, 8'h00);
    reply = 8'h5A;
    wr(8'h00, 8'h40);
    wr(8'h0C, 8'h11);
    wr(8'h0C, 8'h22);
    waitRx();
    rd(8'h10);
    chk("rx first", 8'h5A, rv);
    waitRx();
    rd(8'h10);
    chk("rx second", 8'h5A, rv);
    chk("peer got", 8'h22, got);
    $display("back to back test done");
  endtask
  task automatic t_irq();
    wr(8'h18, 8'h02);
    wr(8'h14, 8'hFF);
    chk("irq clear", 8'h00, {7'h00, irq});
    wr(8'h0C, 8'h00);
    waitRx();
    chk("irq set", 8'h01, {7'h00, irq});
    wr(8'h14, 8'h02);
    chk("irq w1c", 8'h00, {7'h00, irq});
    rd(8'h10);
    $display("interrupt test done");
  endtask
  task automatic t_half();
    wr(8'h00, 8'h00);
    halfSel = 1'b1;
    reply = 8'hC3;
    wr(8'h00, 8'h48);
    chk("oe rx", 8'h00, {7'h00, oe});
    wr(8'h0C, 8'hFF);
    waitRx();
    rd(8'h10);
    chk("half rx", 8'hC3, rv);
    wr(8'h00, 8'h68);
    chk("oe tx", 8'h01, {7'h00, oe});
    $display("half duplex test done");
  endtask
  task automatic t_dual();
    wr(8'h00, 8'h00);
    reply = 8'hC3;
    wr(8'h00, 8'h50);
    chk("oe dual", 8'h00, {7'h00, oe});
    wr(8'h0C, 8'hFF);
    waitRx();
    rd(8'h10);
    chk("dual rx", 8'hA5, rv);
    $display("dual test done");
  endtask
  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset();
    t_full();
    t_b2b();
    t_irq();
    t_half();
    t_dual();
    give_verdict();
  end
endmodule
